// >>> src/port_cfg_pkg.sv
/*
  constants for the port pin cell configuration block: register offsets,
  reset values and pin layout.
  assumes a 32-bit apb slave with one register per aligned word.
*/
package port_cfg_pkg;
  // ==========================================================
  // pin layout
  localparam int NUM_PORTS = 3;
  localparam int PORT_WIDTH = 8;
  localparam int NUM_PINS = NUM_PORTS * PORT_WIDTH;
  // analog capable pins run from port 0 bit 0 to port 1 bit 6
  localparam logic [23:0] ANALOG_CAPABLE = 24'h007fff;
  // radio dedicated pins: port 1 bits 0..3
  localparam logic [23:0] RADIO_RESERVED = 24'h000f00;
  // bonded pins: port 0, port 1 bits 4..6, plus port 2 bit 7
  localparam logic [23:0] GP_PINS = 24'h8070ff;
  localparam int DEBUG_PIN = 23;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_MODE_IN = 12'h000;
  localparam logic [11:0] OFS_MODE_OUT = 12'h004;
  localparam logic [11:0] OFS_DRIVE = 12'h008;
  localparam logic [11:0] OFS_LATCH = 12'h00c;
  localparam logic [11:0] OFS_READ = 12'h010;
  localparam logic [11:0] OFS_CTRL = 12'h014;
  localparam logic [11:0] OFS_PERIPH = 12'h018;
  // ==========================================================
  // reset values and control fields
  localparam logic [23:0] RST_MODE_IN = 24'hffffff;
  localparam logic [23:0] RST_MODE_OUT = 24'h000000;
  localparam logic [23:0] RST_DRIVE = 24'h000000;
  localparam logic [23:0] RST_LATCH = 24'hffffff;
  localparam logic [23:0] RST_PERIPH = 24'h000000;
  localparam int CTRL_ROUTER_BIT = 0;
  localparam int CTRL_PUD_BIT = 1;
  localparam logic [31:0] BUS_ZERO = 32'h00000000;
endpackage

// >>> src/sync_hold_reg.sv
/*
  generic apb-writable register with byte-lane strobes.
  assumes the caller decodes the write select.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_hold_reg #(
  parameter int WIDTH = 24,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write side
  input wire logic wr_en,
  input wire logic [3:0] wr_strb,
  input wire logic [WIDTH-1:0] wr_data,
  // stored value
  output logic [WIDTH-1:0] value
);
  // ==========================================================
  // storage
  // elaboration check: one apb word carries at most 32 bits
  if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
    $error("width out of range");
  end
  // byte lanes update only where strobed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= RESET_VALUE;
    end else if (wr_en) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (wr_strb[i/8]) begin
          value[i] <= wr_data[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/pad_cell.sv
/*
  one port pin cell: mode muxing, driver enables, pull-up and read-back.
  assumes pad input is synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pad_cell #(
  parameter bit ANALOG_OK = 1'b1,
  parameter bit BONDED = 1'b1
) (
  // configuration
  input wire logic digital_sel,
  input wire logic push_pull,
  input wire logic high_drive,
  input wire logic router_en,
  input wire logic pullup_off,
  // output source
  input wire logic periph_sel,
  input wire logic periph_out,
  input wire logic latch_out,
  // pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pad_pullup,
  output logic pad_hi_drive,
  output logic pad_read
);
  // ==========================================================
  // cell behaviour
  logic is_digital;
  logic out_val;
  logic drive;
  // pins without analog path are always digital
  assign is_digital = !ANALOG_OK || digital_sel;
  // peripheral or latch supplies the value
  assign out_val = periph_sel ? periph_out : latch_out;
  // open-drain only pulls low; drivers held off while router is off
  assign drive = BONDED && router_en &&
    (push_pull || !out_val);
  assign pad_out = out_val && push_pull;
  assign pad_oe_n = !drive;
  // pull-up on unless the cell drives low, while bonded, digital and not globally off
  assign pad_pullup = BONDED && is_digital && !pullup_off &&
    !(drive && !pad_out);
  assign pad_hi_drive = high_drive;
  // analog and unbonded pins read zero, bonded digital pins read the pad
  assign pad_read = BONDED && is_digital && pad_in;
endmodule
`default_nettype wire

// >>> src/port_io_cell_config.sv
/*
  port pin cell configuration block: apb register file and 24 pin cells
  (three byte-wide ports, 12 bonded pins).
  assumes pad inputs synchronous to pclk; the wire level is resolved
  outside from pad_out and pad_oe_n.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - twelve pins in three ports, analog capable (pin 23 is digital only here)
// - digital pin serves peripheral or latch
// - radio pins kept from general use
// - debug data pin also usable as gpio
// - mode bit zero analog, one digital
// - reset: digital, floating, pull-ups on
// - analog pin: no pull-up, no receiver
// - analog pin reads back zero
// - output mode one means push-pull
// - open-drain drives low only
// - pull-up on when floating, off low
// - global disable kills all pull-ups
// - digital read returns pad level
// - per-pin drive strength, default low
// - drivers off until router enabled (radio pins and an active debug wire drive regardless of the router)
module port_io_cell_config
  import port_cfg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal peripheral side
  input wire logic [23:0] periph_out,
  // radio link on reserved pins
  input wire logic [3:0] radio_out,
  input wire logic [3:0] radio_oe_n,
  output logic [3:0] radio_in,
  // debug wire data pin
  input wire logic debug_wire_active,
  input wire logic debug_wire_out,
  input wire logic debug_wire_oe_n,
  output logic debug_wire_data_pin,
  // pads
  input wire logic [23:0] pad_in,
  output logic [23:0] pad_out,
  output logic [23:0] pad_oe_n,
  output logic [23:0] pad_pullup,
  output logic [23:0] pad_hi_drive
);
  // ==========================================================
  // bus decode
  logic wr_acc;
  logic rd_setup;
  logic hit;
  logic [31:0] next_prdata;
  logic wr_mode_in, wr_mode_out, wr_drive, wr_latch, wr_ctrl, wr_periph;
  // zero wait state: a write lands on the access edge
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign hit = paddr == OFS_MODE_IN || paddr == OFS_MODE_OUT ||
    paddr == OFS_DRIVE || paddr == OFS_LATCH || paddr == OFS_READ ||
    paddr == OFS_CTRL || paddr == OFS_PERIPH;
  // unmapped addresses answer with an error
  assign pslverr = psel && penable && !hit;
  assign wr_mode_in = wr_acc && paddr == OFS_MODE_IN;
  assign wr_mode_out = wr_acc && paddr == OFS_MODE_OUT;
  assign wr_drive = wr_acc && paddr == OFS_DRIVE;
  assign wr_latch = wr_acc && paddr == OFS_LATCH;
  assign wr_ctrl = wr_acc && paddr == OFS_CTRL;
  assign wr_periph = wr_acc && paddr == OFS_PERIPH;
  // ==========================================================
  // configuration registers
  logic [23:0] pin_analog_digital_select;
  logic [23:0] pin_output_mode_select;
  logic [23:0] pin_drive_strength_select;
  logic [23:0] port_latch;
  logic [23:0] periph_select;
  logic pin_router_enable;
  logic weak_pullup_global_disable;
  // reset leaves every cell digital, so outputs float with pull-ups on
  sync_hold_reg #(.WIDTH(24), .RESET_VALUE(RST_MODE_IN)) u_mode_in (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_mode_in),
    .wr_strb(pstrb), .wr_data(pwdata[23:0]),
    .value(pin_analog_digital_select));
  sync_hold_reg #(.WIDTH(24), .RESET_VALUE(RST_MODE_OUT)) u_mode_out (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_mode_out),
    .wr_strb(pstrb), .wr_data(pwdata[23:0]),
    .value(pin_output_mode_select));
  sync_hold_reg #(.WIDTH(24), .RESET_VALUE(RST_DRIVE)) u_drive (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_drive),
    .wr_strb(pstrb), .wr_data(pwdata[23:0]),
    .value(pin_drive_strength_select));
  sync_hold_reg #(.WIDTH(24), .RESET_VALUE(RST_LATCH)) u_latch (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_latch),
    .wr_strb(pstrb), .wr_data(pwdata[23:0]),
    .value(port_latch));
  sync_hold_reg #(.WIDTH(24), .RESET_VALUE(RST_PERIPH)) u_periph (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_periph),
    .wr_strb(pstrb), .wr_data(pwdata[23:0]),
    .value(periph_select));
  // global control bits; router off at reset keeps the pin cell drivers disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_router_enable <= 1'b0;
      weak_pullup_global_disable <= 1'b0;
    end else if (wr_ctrl && pstrb[0]) begin
      pin_router_enable <= pwdata[CTRL_ROUTER_BIT];
      weak_pullup_global_disable <= pwdata[CTRL_PUD_BIT];
    end
  end
  // ==========================================================
  // pin cells
  logic [23:0] cell_out;
  logic [23:0] cell_oe_n;
  logic [23:0] cell_pullup;
  logic [23:0] pad_read;
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_cell
      // only the twelve bonded pins get a live cell
      pad_cell #(
        .ANALOG_OK(ANALOG_CAPABLE[g]),
        .BONDED(GP_PINS[g])
      ) u_cell (
        .digital_sel(pin_analog_digital_select[g]),
        .push_pull(pin_output_mode_select[g]),
        .high_drive(pin_drive_strength_select[g]),
        .router_en(pin_router_enable),
        .pullup_off(weak_pullup_global_disable),
        .periph_sel(periph_select[g]),
        .periph_out(periph_out[g]),
        .latch_out(port_latch[g]),
        .pad_in(pad_in[g]),
        .pad_out(cell_out[g]),
        .pad_oe_n(cell_oe_n[g]),
        .pad_pullup(cell_pullup[g]),
        .pad_hi_drive(),
        .pad_read(pad_read[g]));
    end
  endgenerate
  // ==========================================================
  // pad muxing for radio and debug pins
  logic [23:0] next_pad_out;
  logic [23:0] next_pad_oe_n;
  logic [23:0] next_pad_pullup;
  // radio pins never reach gpio; the debug wire overrides its pin
  always_comb begin
    next_pad_out = cell_out;
    next_pad_oe_n = cell_oe_n;
    next_pad_pullup = cell_pullup;
    for (int i = 0; i < 4; i++) begin
      next_pad_out[8+i] = radio_out[i];
      next_pad_oe_n[8+i] = radio_oe_n[i];
      next_pad_pullup[8+i] = 1'b0;
    end
    if (debug_wire_active) begin
      next_pad_out[DEBUG_PIN] = debug_wire_out;
      next_pad_oe_n[DEBUG_PIN] = debug_wire_oe_n;
      // the debug wire pulling low must not fight the weak pull-up
      next_pad_pullup[DEBUG_PIN] = cell_pullup[DEBUG_PIN] &&
        (debug_wire_oe_n || debug_wire_out);
    end
  end
  // pad outputs registered so they settle one edge after a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 24'h000000;
      pad_oe_n <= 24'hffffff;
      pad_pullup <= GP_PINS & ~RADIO_RESERVED;
      pad_hi_drive <= RST_DRIVE;
    end else begin
      pad_out <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
      pad_pullup <= next_pad_pullup;
      pad_hi_drive <= pin_drive_strength_select & GP_PINS;
    end
  end
  // radio and debug receivers take the pad through one register, one edge late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radio_in <= 4'h0;
      debug_wire_data_pin <= 1'b0;
    end else begin
      radio_in <= pad_in[11:8];
      debug_wire_data_pin <= pad_in[DEBUG_PIN];
    end
  end
  // ==========================================================
  // read data; radio pins read zero through the port
  always_comb begin
    next_prdata = BUS_ZERO;
    case (paddr)
      OFS_MODE_IN: next_prdata[23:0] = pin_analog_digital_select;
      OFS_MODE_OUT: next_prdata[23:0] = pin_output_mode_select;
      OFS_DRIVE: next_prdata[23:0] = pin_drive_strength_select;
      OFS_LATCH: next_prdata[23:0] = port_latch;
      OFS_READ: next_prdata[23:0] = pad_read & ~RADIO_RESERVED;
      OFS_CTRL: begin
        next_prdata[CTRL_ROUTER_BIT] = pin_router_enable;
        next_prdata[CTRL_PUD_BIT] = weak_pullup_global_disable;
      end
      OFS_PERIPH: next_prdata[23:0] = periph_select;
      default: next_prdata = BUS_ZERO;
    endcase
  end
  // captured in the setup cycle, valid through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= BUS_ZERO;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// >>> verif/port_io_cell_config_props.sv
/*
  checker for the port cell block: pad enables, pull-ups, read-back copies.
  assumes it is bound to port_io_cell_config and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module port_cell_checker
  import port_cfg_pkg::*;
(
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // radio and debug
  input wire logic [3:0] radio_oe_n,
  input wire logic [3:0] radio_in,
  input wire logic debug_wire_data_pin,
  // pads
  input wire logic [23:0] pad_in,
  input wire logic [23:0] pad_out,
  input wire logic [23:0] pad_oe_n,
  input wire logic [23:0] pad_pullup
);
  // ==========================================================
  // helper logic
  localparam logic [23:0] UNUSED = ~(GP_PINS | RADIO_RESERVED);
  // the debug pin may be driven by the debug wire, so it is left out
  localparam logic [23:0] ROUTED = GP_PINS & 24'h7fffff;
  logic [1:0] ctl_q;
  wire logic [3:0] radio_pad = pad_in[11:8];
  wire logic dbg_pad = pad_in[DEBUG_PIN];
  // shadow of the control word, lane 0 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 2'b00;
    end else if (psel && penable && pwrite && paddr == OFS_CTRL && pstrb[0]) begin
      ctl_q <= pwdata[1:0];
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // assertions
  chk_unused_quiet: assert property (
    (pad_oe_n & UNUSED) == UNUSED && (pad_pullup & UNUSED) == '0)
    else $error("unbonded pin active");
  chk_radio_follow: assert property (
    $past(presetn) |-> pad_oe_n[11:8] == $past(radio_oe_n))
    else $error("radio pin enable wrong");
  chk_radio_copy: assert property (
    $past(presetn) |-> radio_in == $past(radio_pad))
    else $error("radio input copy wrong");
  chk_debug_copy: assert property (
    $past(presetn) |-> debug_wire_data_pin == $past(dbg_pad))
    else $error("debug pin copy wrong");
  chk_router_gate: assert property (
    !$past(ctl_q[0]) |-> (pad_oe_n & ROUTED) == ROUTED)
    else $error("driver on without router");
  chk_pud_all: assert property (
    $past(ctl_q[1]) |-> pad_pullup == '0)
    else $error("pull-up on under global disable");
  chk_no_pull_low: assert property (
    (pad_pullup & ~pad_oe_n & ~pad_out) == '0)
    else $error("pull-up on while driving low");
  chk_reset_state: assert property (
    $rose(presetn) |-> pad_oe_n == '1 && pad_pullup == GP_PINS)
    else $error("pad reset state wrong");
  cover property (ctl_q == 2'b01 && pad_oe_n[0] == 1'b0);
  cover property ($rose(ctl_q[1]));
  cover property (psel && penable && paddr == OFS_READ);
endmodule
bind port_io_cell_config port_cell_checker i_port_cell_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .radio_oe_n(radio_oe_n), .radio_in(radio_in),
  .debug_wire_data_pin(debug_wire_data_pin), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup));
`default_nettype wire

// >>> verif/pad_board_model.sv
/*
  board model for the pads: resolves each wire from the cell and the board.
  assumes the bench sets ext_en and ext_val off the clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pad_board_model (
  // clock
  input wire logic pclk,
  // cell side
  input wire logic [23:0] pad_out,
  input wire logic [23:0] pad_oe_n,
  input wire logic [23:0] pad_pullup,
  // board drive
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  // sensed level
  output logic [23:0] pad_in
);
  logic tog = 1'b0;
  // a floating pad with no pull changes every cycle, never holds a value
  always_ff @(posedge pclk) begin
    tog <= ~tog;
  end
  // cell driver wins, then the board, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                  pad_pullup[i] | tog;
    end
  end
endmodule
`default_nettype wire

// >>> verif/port_io_cell_config_test.sv
/*
  testbench for the port cell block: apb master, board model, scenarios.
  assumes a 100 MHz pclk and the register map of port_cfg_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module port_io_cell_config_test
  import port_cfg_pkg::*;
;
  // ==========================================================
  // signals
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, dbg_in, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, radio_in;
  logic [3:0] radio_out = 4'ha, radio_oe_n = 4'h0;
  logic debug_wire_active = 1'b0, debug_wire_out = 1'b0;
  logic debug_wire_oe_n = 1'b1;
  logic [23:0] periph_out = '0, ext_en = '0, ext_val = '0, pad_in;
  logic [23:0] pad_out, pad_oe_n, pad_pullup, pad_hi_drive;
  int n_errors = 0, samples_checked = 0;
  logic [11:0] ofs [6] = '{OFS_MODE_IN, OFS_MODE_OUT, OFS_DRIVE, OFS_LATCH,
                           OFS_CTRL, OFS_PERIPH};
  logic [23:0] rst [6] = '{RST_MODE_IN, RST_MODE_OUT, RST_DRIVE, RST_LATCH,
                           24'h0, RST_PERIPH};
  always #5 pclk = ~pclk;
  port_io_cell_config i_port_io_cell_config (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_out(periph_out), .radio_out(radio_out),
    .radio_oe_n(radio_oe_n), .radio_in(radio_in),
    .debug_wire_active(debug_wire_active),
    .debug_wire_out(debug_wire_out), .debug_wire_oe_n(debug_wire_oe_n),
    .debug_wire_data_pin(dbg_in), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
    .pad_hi_drive(pad_hi_drive));
  pad_board_model i_pad_board_model (.pclk(pclk), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));
  // ==========================================================
  // shared tasks
  task automatic check(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // pads follow one edge after the write edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge pclk);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
    apb(1'b0, a, '0);
    check(nm, rd, e);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_gpio;
    wr(OFS_MODE_OUT, 32'h1);
    wr(OFS_LATCH, 32'hfffffe);
    check("oe_off", pad_oe_n[1:0], 2'b11);
    wr(OFS_CTRL, 32'h1);
    check("st_a", {pad_oe_n[1:0], pad_out[0], pad_pullup[1:0]}, 5'b10010);
    wr(OFS_LATCH, 32'hfffffd);
    check("st_b", {pad_oe_n[1:0], pad_out[1:0], pad_pullup[1:0]}, 6'h05);
    wr(OFS_CTRL, 32'h3);
    check("pud", pad_pullup, 24'h0);
    wr(OFS_CTRL, 32'h1);
  endtask
  task automatic t_read;
    // pin2 stays open-drain with latch high, so its drivers are off
    wr(OFS_MODE_IN, 32'h7ffffb);
    check("an_pu", pad_pullup[2], 1'b0);
    ext_en <= 24'hfffffc;
    ext_val <= 24'hffffff;
    repeat (2) @(posedge pclk);
    rd_chk("rd_hi", OFS_READ, 32'h8070f9);
    ext_val <= 24'h0;
    repeat (2) @(posedge pclk);
    rd_chk("rd_lo", OFS_READ, 32'h1);
    ext_en <= '0;
  endtask
  task automatic t_misc;
    wr(OFS_DRIVE, 32'h800001);
    check("hd", pad_hi_drive, 24'h800001);
    wr(OFS_PERIPH, 32'h1);
    check("per0", pad_out[0], 1'b0);
    periph_out <= 24'h1;
    repeat (2) @(posedge pclk);
    check("per1", pad_out[0], 1'b1);
    rd_chk("unmap", 12'h01c, 32'h0);
    check("err", er, 1'b1);
    pstrb <= 4'he;
    wr(OFS_CTRL, 32'h0);
    pstrb <= 4'hf;
    check("strb", pad_oe_n[0], 1'b0);
    check("radio", {pad_oe_n[11:8], pad_out[11:8], radio_in}, 12'h0aa);
  endtask
  // radio link released, then the debug wire takes over its pin
  task automatic t_links;
    radio_oe_n <= 4'hf;
    radio_out <= 4'h5;
    ext_en <= 24'h800f00;
    ext_val <= 24'h000300;
    repeat (3) @(posedge pclk);
    check("rad_rel", {pad_oe_n[11:8], pad_out[11:8], radio_in}, 12'hf53);
    check("dbg_gp", dbg_in, 1'b0);
    rd_chk("rad_rd", OFS_READ, 32'h0070f9);
    debug_wire_active <= 1'b1;
    debug_wire_oe_n <= 1'b0;
    debug_wire_out <= 1'b0;
    ext_en <= '0;
    repeat (3) @(posedge pclk);
    check("dbg_lo", {pad_oe_n[23], pad_out[23], dbg_in}, 3'b000);
    check("dbg_pu", pad_pullup[23], 1'b0);
    debug_wire_out <= 1'b1;
    repeat (3) @(posedge pclk);
    check("dbg_hi", {pad_oe_n[23], pad_out[23], dbg_in}, 3'b011);
    rd_chk("dbg_rd", OFS_READ, 32'h8070f9);
    debug_wire_active <= 1'b0;
  endtask
  // reset in mid-run brings every cell back to its defaults
  task automatic t_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("oe_rst2", pad_oe_n, 24'hffffff);
    check("pu_rst2", pad_pullup, GP_PINS);
    check("hd_rst2", pad_hi_drive, 24'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("ctl_rst2", OFS_CTRL, 32'h0);
    rd_chk("md_rst2", OFS_MODE_IN, 32'hffffff);
    rd_chk("hd_rst3", OFS_DRIVE, 32'h0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    check("oe_rst", pad_oe_n, 24'hffffff);
    check("pu_rst", pad_pullup, GP_PINS);
    check("hd_rst", pad_hi_drive, 24'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      rd_chk("reg_rst", ofs[i], {8'h00, rst[i]});
    end
    t_gpio();
    t_read();
    t_misc();
    t_links();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
